// [sfps_pkg.sv]
package sfps_pkg;
  localparam int         CLOCK_MHZ          = 40;
  localparam logic [7:0] CMD_WRITE_ENABLE   = 8'h06;
  localparam logic [7:0] CMD_WRITE_DISABLE  = 8'h04;
  localparam logic [7:0] CMD_PAGE_PROG      = 8'h02;
  localparam logic [7:0] CMD_DUAL_PROG      = 8'ha2;
  localparam logic [7:0] CMD_EXT_DUAL_PROG  = 8'hd2;
  localparam logic [7:0] CMD_QUAD_PROG      = 8'h32;
  localparam logic [7:0] CMD_EXT_QUAD_PROG  = 8'h38;
  localparam logic [7:0] CMD_SUBSECTOR_ERA  = 8'h20;
  localparam logic [7:0] CMD_SECTOR_ERA     = 8'hd8;
  localparam logic [7:0] CMD_SUSPEND        = 8'h75;
  localparam logic [7:0] CMD_RESUME         = 8'h7a;
  localparam int         PAGE_BYTES         = 256;
  localparam logic [7:0] PAGE_LAST          = 8'hff;
  localparam logic [2:0] STAGE_CMD_DONE     = 3'h1;
  localparam logic [2:0] STAGE_ADDR_DONE    = 3'h4;
  localparam logic       WEL_RESET          = 1'b0;
  localparam logic [7:0] FLAG_RESET         = 8'h00;
  localparam int         FLAG_PROTECT       = 1;
  localparam int         FLAG_PROG_SUSPEND  = 2;
  localparam int         FLAG_PROGRAM       = 4;
  localparam int         FLAG_ERASE         = 5;
  localparam int         FLAG_ERASE_SUSPEND = 6;
  localparam logic [7:0] FLAG_ERROR_MASK    = 8'h32;
  localparam logic [7:0] FLAG_SUSPEND_MASK  = 8'h44;
  localparam int         PROGRAM_TIME_US    = 500;
  localparam int         SUBSECTOR_TIME_US  = 50000;
  localparam int         SECTOR_TIME_US     = 200000;
  localparam int         PROGRAM_CYCLES     = PROGRAM_TIME_US * CLOCK_MHZ;
  localparam int         SUBSECTOR_CYCLES   = SUBSECTOR_TIME_US * CLOCK_MHZ;
  localparam int         SECTOR_CYCLES      = SECTOR_TIME_US * CLOCK_MHZ;

  typedef enum logic [1:0] {
    PROTO_EXTENDED = 2'h0,
    PROTO_DUAL     = 2'h1,
    PROTO_QUAD     = 2'h2
  } sfps_proto_t;

  typedef struct packed {
    logic        seq;
    logic [7:0]  code;
    logic [23:0] addr;
    logic [2:0]  stage;
    logic        aligned;
    logic        has_data;
  } sfps_frame_t;

  function automatic logic [2:0] sfps_lanes(input sfps_proto_t proto, input logic [7:0] code,
                                            input logic [2:0] stage);
    logic [2:0] w;
    w = (proto == PROTO_QUAD) ? 3'h4 : ((proto == PROTO_DUAL) ? 3'h2 : 3'h1);
    if (stage != 3'h0 && proto == PROTO_EXTENDED) begin
      if (code == CMD_EXT_DUAL_PROG || (stage == STAGE_ADDR_DONE && code == CMD_DUAL_PROG))
        w = 3'h2;
      if (code == CMD_EXT_QUAD_PROG || (stage == STAGE_ADDR_DONE && code == CMD_QUAD_PROG))
        w = 3'h4;
    end
    return w;
  endfunction : sfps_lanes

  function automatic logic [7:0] sfps_shift(input logic [7:0] sh, input logic [3:0] dq,
                                            input logic [2:0] w);
    case (w)
      3'h4:    return {sh[3:0], dq};
      3'h2:    return {sh[5:0], dq[1:0]};
      default: return {sh[6:0], dq[0]};
    endcase
  endfunction : sfps_shift
endpackage : sfps_pkg

// [sfps_seq.sv]
// Operation
// - write-enable code 06h sets enable latch
// - write-disable code 04h clears enable latch
// - enable codes use one, two, four lanes
// - enable commands act only at select rise
// - no select rise: latch unchanged, no flags
// - program is code, address, data bytes
// - unaligned program wraps within the page
// - overflow keeps only last page of bytes
// - short program touches only addressed bytes
// - busy sets in-progress, clears enable latch
// - program timeout clears latch, sets fail
// - protected program: latch kept, flags 1,4
// - no byte-boundary rise: command dropped silently
// - erase without enable latch is ignored
// - subsector erase: code plus three address bytes
// - sector erase: code plus three address bytes
// - erase timeout clears latch, sets error
// - protected erase: latch kept, flags 1,5
// - address bits sampled on rising serial clock
// - suspend pauses, resume continues the operation
// - program variants pick address and data lanes
// - program variants allowed per protocol only
// - addresses are 24 bits in three bytes
module sfps_seq
  import sfps_pkg::*;
#(
  parameter int unsigned PROGRAM_CYCLES_P   = PROGRAM_CYCLES,
  parameter int unsigned SUBSECTOR_CYCLES_P = SUBSECTOR_CYCLES,
  parameter int unsigned SECTOR_CYCLES_P    = SECTOR_CYCLES
) (
  // system
  input  wire logic        clock,
  input  wire logic        reset_n,
  // serial link
  input  wire logic        serial_clock,
  input  wire logic        chip_select_n,
  input  wire logic [3:0]  lanes,
  // configuration
  input  wire sfps_proto_t protocol,
  input  wire logic        clear_flags,
  // protection lookup
  output logic [23:0]      check_addr,
  input  wire logic        check_protected,
  // array
  output logic             array_wr_valid,
  output logic [23:0]      array_addr,
  output logic [7:0]       array_wr_data,
  output logic             erase_start,
  output logic             erase_sector,
  input  wire logic        array_ok,
  // status
  output logic             write_enable_latch,
  output logic             write_in_progress,
  output logic [7:0]       flag_status
);
  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_CHECK = 4'b0010,
    ST_WRITE = 4'b0100,
    ST_TIME  = 4'b1000
  } sfps_state_t;

  sfps_state_t state, next_state;
  sfps_frame_t frame;
  logic        link_clear, frame_rst, busy, busy_s1, busy_s2;
  sfps_proto_t proto_hold;
  logic [2:0]  bit_cnt, byte_idx, lanes_now;
  logic [3:0]  next_bits;
  logic [7:0]  next_sh, shreg, wr_ptr, wr_index, walk_idx;
  logic        byte_done, data_byte, prog_code_sh;
  logic [7:0]  page_buf [PAGE_BYTES];
  logic [PAGE_BYTES-1:0] page_mask;

  // link side: the select pin ends every frame, and link_clear also resets the counters
  assign frame_rst = chip_select_n | link_clear;
  assign lanes_now = sfps_lanes(proto_hold, frame.code, byte_idx);
  assign next_sh   = sfps_shift(shreg, lanes, lanes_now);
  assign next_bits = {1'b0, bit_cnt} + {1'b0, lanes_now};
  assign byte_done = next_bits == 4'h8;
  assign data_byte = byte_done && byte_idx == STAGE_ADDR_DONE;
  assign wr_index  = frame.addr[7:0] + wr_ptr;
  assign prog_code_sh = next_sh inside {CMD_PAGE_PROG, CMD_DUAL_PROG, CMD_EXT_DUAL_PROG,
                                        CMD_QUAD_PROG, CMD_EXT_QUAD_PROG};

  always_ff @(posedge serial_clock or posedge link_clear) begin
    if (link_clear) begin
      busy_s1 <= 1'b0;
      busy_s2 <= 1'b0;
    end else begin
      busy_s1 <= busy;
      busy_s2 <= busy_s1;
    end
  end

  always_ff @(posedge serial_clock or posedge frame_rst) begin
    if (frame_rst) begin
      bit_cnt  <= 3'h0;
      byte_idx <= 3'h0;
      shreg    <= 8'h00;
      wr_ptr   <= 8'h00;
    end else begin
      bit_cnt <= next_bits[2:0];
      shreg   <= next_sh;
      if (byte_done && byte_idx != STAGE_ADDR_DONE)
        byte_idx <= byte_idx + 3'h1;
      if (data_byte)
        wr_ptr <= wr_ptr + 8'h01;
    end
  end

  // summary survives the select rise so the system side can read it while the link idles
  always_ff @(posedge serial_clock or posedge link_clear) begin
    if (link_clear) begin
      frame <= '0;
    end else begin
      if (bit_cnt == 3'h0 && byte_idx == 3'h0)
        frame.seq <= ~frame.seq;
      frame.aligned <= byte_done;
      if (byte_done && byte_idx != STAGE_ADDR_DONE)
        frame.stage <= byte_idx + 3'h1;
      else
        frame.stage <= byte_idx;
      if (byte_done && byte_idx == 3'h0)
        frame.code <= next_sh;
      if (byte_done && byte_idx != 3'h0 && byte_idx != STAGE_ADDR_DONE)
        frame.addr <= {frame.addr[15:0], next_sh};
      frame.has_data <= data_byte || (frame.has_data && byte_idx == STAGE_ADDR_DONE);
    end
  end

  // buffer is frozen while the system side walks it; a frame racing busy may still land
  always_ff @(posedge serial_clock) begin
    if (data_byte && !busy_s2)
      page_buf[wr_index] <= next_sh;
  end

  always_ff @(posedge serial_clock or posedge link_clear) begin
    if (link_clear) begin
      page_mask <= '0;
    end else if (!busy_s2) begin
      if (byte_done && byte_idx == 3'h0 && prog_code_sh)
        page_mask <= '0;
      else if (data_byte)
        page_mask[wr_index] <= 1'b1;
    end
  end

  // system side
  logic cs_s1, cs_s2, cs_s3, seq_seen, suspended, op_is_prog;
  logic fresh, cmd_end, addr_end, data_end, prog_code, prog_ok, erase_code;
  logic start_op, susp_req, resume_req, time_up;
  logic [31:0] timer, limit;
  logic [7:0]  flag_set, flag_clr;

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      cs_s1 <= 1'b1;
      cs_s2 <= 1'b1;
      cs_s3 <= 1'b1;
    end else begin
      cs_s1 <= chip_select_n;
      cs_s2 <= cs_s1;
      cs_s3 <= cs_s2;
    end
  end

  // held while a frame runs: the link clock stops between frames, so a sync there goes stale
  always_ff @(posedge clock) begin
    if (!reset_n)
      proto_hold <= PROTO_EXTENDED;
    else if (cs_s2)
      proto_hold <= protocol;
  end

  always_ff @(posedge clock) begin
    link_clear <= ~reset_n;
    busy       <= reset_n && next_state != ST_IDLE;
  end

  always_comb begin
    fresh      = cs_s2 && !cs_s3 && frame.seq != seq_seen;
    cmd_end    = frame.aligned && frame.stage == STAGE_CMD_DONE && !frame.has_data;
    addr_end   = frame.aligned && frame.stage == STAGE_ADDR_DONE && !frame.has_data;
    data_end   = frame.aligned && frame.has_data;
    prog_code  = frame.code inside {CMD_PAGE_PROG, CMD_DUAL_PROG, CMD_EXT_DUAL_PROG,
                                    CMD_QUAD_PROG, CMD_EXT_QUAD_PROG};
    erase_code = frame.code == CMD_SUBSECTOR_ERA || frame.code == CMD_SECTOR_ERA;
    prog_ok    = frame.code == CMD_PAGE_PROG ||
                 ((frame.code == CMD_DUAL_PROG || frame.code == CMD_EXT_DUAL_PROG) &&
                  protocol != PROTO_QUAD) ||
                 ((frame.code == CMD_QUAD_PROG || frame.code == CMD_EXT_QUAD_PROG) &&
                  protocol != PROTO_DUAL);
    start_op   = fresh && state == ST_IDLE && write_enable_latch &&
                 ((prog_code && prog_ok && data_end) || (erase_code && addr_end));
    susp_req   = fresh && !suspended && frame.code == CMD_SUSPEND && cmd_end &&
                 (state == ST_WRITE || state == ST_TIME);
    resume_req = fresh && suspended && frame.code == CMD_RESUME && cmd_end;
    limit      = op_is_prog ? 32'(PROGRAM_CYCLES_P) :
                 (erase_sector ? 32'(SECTOR_CYCLES_P) : 32'(SUBSECTOR_CYCLES_P));
    time_up    = state == ST_TIME && !suspended && timer == limit - 32'h1;
  end

  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE:  if (start_op) next_state = ST_CHECK;
      ST_CHECK: next_state = check_protected ? ST_IDLE : (op_is_prog ? ST_WRITE : ST_TIME);
      ST_WRITE: if (walk_idx == PAGE_LAST) next_state = ST_TIME;
      ST_TIME:  if (time_up) next_state = ST_IDLE;
      default:  next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge clock) begin
    if (!reset_n)
      state <= ST_IDLE;
    else
      state <= next_state;
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      seq_seen     <= 1'b0;
      check_addr   <= 24'h000000;
      op_is_prog   <= 1'b0;
      erase_sector <= 1'b0;
    end else begin
      if (cs_s2 && !cs_s3)
        seq_seen <= frame.seq;
      if (start_op) begin
        check_addr   <= frame.addr;
        op_is_prog   <= prog_code;
        erase_sector <= frame.code == CMD_SECTOR_ERA;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n)
      write_enable_latch <= WEL_RESET;
    else if ((state == ST_CHECK && !check_protected) || time_up)
      write_enable_latch <= 1'b0;
    else if (fresh && state == ST_IDLE && cmd_end && frame.code == CMD_WRITE_ENABLE)
      write_enable_latch <= 1'b1;
    else if (fresh && state == ST_IDLE && cmd_end && frame.code == CMD_WRITE_DISABLE)
      write_enable_latch <= 1'b0;
  end

  always_ff @(posedge clock) begin
    if (!reset_n)
      write_in_progress <= 1'b0;
    else if (state == ST_CHECK && !check_protected)
      write_in_progress <= 1'b1;
    else if (time_up)
      write_in_progress <= 1'b0;
  end

  always_comb begin
    flag_set = 8'h00;
    flag_clr = clear_flags ? FLAG_ERROR_MASK : 8'h00;
    if (state == ST_CHECK && check_protected) begin
      flag_set[FLAG_PROTECT] = 1'b1;
      flag_set[op_is_prog ? FLAG_PROGRAM : FLAG_ERASE] = 1'b1;
    end
    if (time_up && !array_ok)
      flag_set[op_is_prog ? FLAG_PROGRAM : FLAG_ERASE] = 1'b1;
    if (susp_req)
      flag_set[op_is_prog ? FLAG_PROG_SUSPEND : FLAG_ERASE_SUSPEND] = 1'b1;
    if (resume_req || time_up)
      flag_clr = flag_clr | FLAG_SUSPEND_MASK;
  end

  // set wins over a clear in the same cycle
  always_ff @(posedge clock) begin
    if (!reset_n)
      flag_status <= FLAG_RESET;
    else
      flag_status <= (flag_status & ~flag_clr) | flag_set;
  end

  always_ff @(posedge clock) begin
    if (!reset_n)
      suspended <= 1'b0;
    else if (susp_req)
      suspended <= 1'b1;
    else if (resume_req || state == ST_IDLE)
      suspended <= 1'b0;
  end

  always_ff @(posedge clock) begin
    if (!reset_n)
      timer <= 32'h0;
    else if (state != ST_TIME)
      timer <= 32'h0;
    else if (!suspended)
      timer <= timer + 32'h1;
  end

  // page walk: only bytes written in the frame reach the array
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      walk_idx       <= 8'h00;
      array_wr_valid <= 1'b0;
      array_addr     <= 24'h000000;
      array_wr_data  <= 8'h00;
      erase_start    <= 1'b0;
    end else begin
      array_wr_valid <= state == ST_WRITE && page_mask[walk_idx];
      erase_start    <= state == ST_CHECK && !check_protected && !op_is_prog;
      walk_idx       <= (state == ST_WRITE) ? walk_idx + 8'h01 : 8'h00;
      if (state == ST_WRITE) begin
        array_addr    <= {check_addr[23:8], walk_idx};
        array_wr_data <= page_buf[walk_idx];
      end else if (state == ST_CHECK) begin
        array_addr    <= check_addr;
      end
    end
  end

  wel_set_a: assert property (@(posedge clock) disable iff (!reset_n)
    (fresh && state == ST_IDLE && cmd_end && frame.code == CMD_WRITE_ENABLE)
    |=> write_enable_latch) else $error("enable latch not set");
  wel_clear_a: assert property (@(posedge clock) disable iff (!reset_n)
    (fresh && state == ST_IDLE && cmd_end && frame.code == CMD_WRITE_DISABLE)
    |=> !write_enable_latch) else $error("enable latch not cleared");
  busy_latch_a: assert property (@(posedge clock) disable iff (!reset_n)
    write_in_progress |-> !write_enable_latch) else $error("latch set while busy");
  protect_keep_a: assert property (@(posedge clock) disable iff (!reset_n)
    (state == ST_CHECK && check_protected) |=> (write_enable_latch &&
    flag_status[FLAG_PROTECT] && !write_in_progress && state == ST_IDLE))
    else $error("protected command ran");
  no_enable_a: assert property (@(posedge clock) disable iff (!reset_n)
    (fresh && state == ST_IDLE && !write_enable_latch && !clear_flags) |=>
    (state == ST_IDLE && $stable(flag_status))) else $error("command ran without latch");
  boundary_drop_a: assert property (@(posedge clock) disable iff (!reset_n)
    (fresh && state == ST_IDLE && !frame.aligned) |=>
    (state == ST_IDLE && $stable(write_enable_latch))) else $error("unaligned frame acted");
  timeout_flag_a: assert property (@(posedge clock) disable iff (!reset_n)
    (time_up && !array_ok) |=> (!write_in_progress && !write_enable_latch &&
    (flag_status[FLAG_PROGRAM] || flag_status[FLAG_ERASE]))) else $error("timeout lost");
  page_wrap_a: assert property (@(posedge clock) disable iff (!reset_n)
    array_wr_valid |-> array_addr[23:8] == check_addr[23:8]) else $error("left the page");
  suspend_hold_a: assert property (@(posedge clock) disable iff (!reset_n)
    (state == ST_TIME && suspended) |=> $stable(timer)) else $error("timer ran suspended");
  erase_pulse_a: assert property (@(posedge clock) disable iff (!reset_n)
    erase_start |=> !erase_start) else $error("erase start held");
  erase_addr_a: assert property (@(posedge clock) disable iff (!reset_n)
    erase_start |-> array_addr == check_addr) else $error("erase address wrong");
  erase_timed_a: assert property (@(posedge clock) disable iff (!reset_n)
    (state == ST_CHECK && !op_is_prog && !check_protected) |=> state == ST_TIME)
    else $error("erase skipped its timer");
  busy_start_a: assert property (@(posedge clock) disable iff (!reset_n)
    (state == ST_CHECK && !check_protected) |=> (write_in_progress && !write_enable_latch))
    else $error("busy not raised");
  busy_end_a: assert property (@(posedge clock) disable iff (!reset_n)
    time_up |=> (!write_in_progress && state == ST_IDLE)) else $error("busy not ended");
  busy_enable_a: assert property (@(posedge clock) disable iff (!reset_n)
    (fresh && write_in_progress && cmd_end && frame.code == CMD_WRITE_ENABLE) |=>
    !write_enable_latch) else $error("latch set during busy");
  prog_fail_a: assert property (@(posedge clock) disable iff (!reset_n)
    (time_up && !array_ok && op_is_prog) |=> flag_status[FLAG_PROGRAM])
    else $error("program fail flag lost");
  erase_fail_a: assert property (@(posedge clock) disable iff (!reset_n)
    (time_up && !array_ok && !op_is_prog) |=> (flag_status[FLAG_ERASE] && !write_enable_latch))
    else $error("erase error flag lost");
  erase_protect_a: assert property (@(posedge clock) disable iff (!reset_n)
    (state == ST_CHECK && check_protected && !op_is_prog) |=> (write_enable_latch &&
    flag_status[FLAG_PROTECT] && flag_status[FLAG_ERASE])) else $error("protected erase ran");
  variant_refuse_a: assert property (@(posedge clock) disable iff (!reset_n)
    (fresh && state == ST_IDLE && prog_code && !prog_ok) |=> state == ST_IDLE)
    else $error("variant ran in wrong protocol");
  walk_mask_a: assert property (@(posedge clock) disable iff (!reset_n)
    (state == ST_WRITE && !page_mask[walk_idx]) |=> !array_wr_valid)
    else $error("stray write");
  suspend_flag_a: assert property (@(posedge clock) disable iff (!reset_n)
    (susp_req && op_is_prog) |=> flag_status[FLAG_PROG_SUSPEND])
    else $error("no suspend flag");
  drop_flags_a: assert property (@(posedge clock) disable iff (!reset_n)
    (fresh && state == ST_IDLE && !frame.aligned && !clear_flags) |=> $stable(flag_status))
    else $error("dropped frame set flags");
endmodule : sfps_seq

// [sfps_host.sv]
module sfps_host (
  // serial link driven toward the device
  output logic       serial_clock,
  output logic       chip_select_n,
  output logic [3:0] lanes
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [3:0] last;

  initial begin
    serial_clock  = 1'b0;
    chip_select_n = 1'b1;
    lanes         = 4'h5;
    last          = 4'h5;
  end

  // lanes move while the clock is low so the rising edge sees settled bits
  task automatic put(input logic [3:0] v);
    lanes = v;
    last  = v;
    #12;
    serial_clock = 1'b1;
    #24;
    serial_clock = 1'b0;
    #12;
  endtask : put

  // code, three address bytes, data; msb first on the active lanes
  // ex adds single bits after the last byte to miss the byte boundary
  task automatic frame(input logic [7:0] b[$], input int cw, aw, dw, ex);
    int w;
    chip_select_n = 1'b0;
    #12;
    foreach (b[k]) begin
      w = (k == 0) ? cw : ((k < 4) ? aw : dw);
      for (int i = 8 - w; i >= 0; i -= w) begin
        put(4'((b[k] >> i) & ((1 << w) - 1)));
      end
    end
    repeat (ex) put(4'h1);
    #12;
    chip_select_n = 1'b1;  // the command acts on this rise only
    lanes         = ~last;  // released lanes must not keep the old value
  endtask : frame
endmodule : sfps_host

// [serial_flash_program_erase_seq_tb_top.sv]
module serial_flash_program_erase_seq_tb_top;
  import sfps_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clock, reset_n, clear_flags, prot, ok;
  sfps_proto_t protocol;
  logic        serial_clock, chip_select_n;
  logic [3:0]  lanes;
  logic [23:0] check_addr, array_addr, er_addr;
  logic        array_wr_valid, erase_start, erase_sector, er_sec;
  logic        write_enable_latch, write_in_progress;
  logic [7:0]  array_wr_data, flag_status;
  logic [7:0]  mem [logic [23:0]];
  logic [7:0]  q[$];
  int          nwr, ner, n_mismatch, compares;

  sfps_host host (
    .serial_clock (serial_clock),
    .chip_select_n(chip_select_n),
    .lanes        (lanes)
  );

  // short timed windows keep the run small
  sfps_seq #(.PROGRAM_CYCLES_P(400), .SUBSECTOR_CYCLES_P(30), .SECTOR_CYCLES_P(40)) dut (
    .clock(clock), .reset_n(reset_n), .serial_clock(serial_clock),
    .chip_select_n(chip_select_n), .lanes(lanes), .protocol(protocol),
    .clear_flags(clear_flags), .check_addr(check_addr), .check_protected(prot),
    .array_wr_valid(array_wr_valid), .array_addr(array_addr), .array_wr_data(array_wr_data),
    .erase_start(erase_start), .erase_sector(erase_sector), .array_ok(ok),
    .write_enable_latch(write_enable_latch), .write_in_progress(write_in_progress),
    .flag_status(flag_status)
  );

  // array model: records every byte write and erase start
  always @(posedge clock) begin
    if (array_wr_valid === 1'b1) begin
      mem[array_addr] = array_wr_data;
      nwr++;
    end
    if (erase_start === 1'b1) begin
      er_addr = array_addr;
      er_sec  = erase_sector;
      ner++;
    end
  end

  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : cyc

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: %s", $time, m);
    end
  endtask : chk

  // e is {latch, busy, flags}
  task automatic st(input logic [9:0] e, input string m);
    chk({write_enable_latch, write_in_progress, flag_status}, e, m);
  endtask : st

  task automatic close_out;
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : close_out

  // eight idle clocks cover the answer latency and the gap between frames
  task automatic fr(input logic [7:0] b[$], input int cw = 1, aw = 1, dw = 1, ex = 0);
    host.frame(b, cw, aw, dw, ex);
    cyc(8);
  endtask : fr

  task automatic prog(input logic [7:0] b[$], input int cw, aw, dw);
    fr('{CMD_WRITE_ENABLE}, cw, cw, cw);
    mem.delete();
    nwr = 0;
    ner = 0;
    fr(b, cw, aw, dw);
  endtask : prog

  task automatic done;
    for (int i = 0; i < 3000 && write_in_progress !== 1'b0; i++) cyc(1);
    if (write_in_progress !== 1'b0) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: busy never ends", $time);
      close_out();
    end
  endtask : done

  task automatic cfg(input logic p, input logic o, input sfps_proto_t pr);
    @(posedge clock);
    prot     <= p;
    ok       <= o;
    protocol <= pr;
    cyc(1);
  endtask : cfg

  task automatic clr;
    @(posedge clock);
    clear_flags <= 1'b1;
    @(posedge clock);
    clear_flags <= 1'b0;
    cyc(2);
  endtask : clr

  initial begin
    reset_n     = 1'b0;
    clear_flags = 1'b0;
    prot        = 1'b0;
    ok          = 1'b1;
    protocol    = PROTO_EXTENDED;
    nwr         = 0;
    ner         = 0;
    n_mismatch  = 0;
    compares    = 0;
    repeat (3) @(posedge clock);
    reset_n <= 1'b1;
    cyc(3);
    st(10'h000, "reset");
    fr('{CMD_WRITE_ENABLE}, 1, 1, 1, 1);
    st(10'h000, "wren off boundary");
    fr('{CMD_WRITE_ENABLE});
    st(10'h200, "wren");
    fr('{CMD_WRITE_DISABLE}, 1, 1, 1, 3);
    st(10'h200, "wrdi off boundary");
    fr('{CMD_WRITE_DISABLE});
    st(10'h000, "wrdi");
    fr('{CMD_SECTOR_ERA, 8'h01, 8'h00, 8'h00});
    st(10'h000, "erase no latch");
    chk(ner, 0, "erase no latch started");
    $display("test latch done");
    prog('{CMD_PAGE_PROG, 8'h00, 8'h12, 8'hfe, 8'ha1, 8'ha2, 8'ha3}, 1, 1, 1);
    st(10'h100, "program busy");
    done();
    st(10'h000, "program end");
    chk(nwr, 3, "short write count");
    chk(mem[24'h0012fe], 8'ha1, "first byte");
    chk(mem[24'h0012ff], 8'ha2, "page end");
    chk(mem[24'h001200], 8'ha3, "wrapped byte");
    q = '{CMD_PAGE_PROG, 8'h00, 8'h04, 8'h00};
    for (int n = 0; n < 258; n++) q.push_back(8'(n) ^ ((n >= 256) ? 8'hff : 8'h00));
    prog(q, 1, 1, 1);
    done();
    chk(nwr, 256, "overflow count");
    chk(mem[24'h000400], 8'hff, "overflow 0");
    chk(mem[24'h000401], 8'hfe, "overflow 1");
    chk(mem[24'h000402], 8'h02, "overflow 2");
    $display("test page done");
    cfg(1'b0, 1'b0, PROTO_EXTENDED);
    prog('{CMD_PAGE_PROG, 8'h00, 8'h20, 8'h00, 8'h55}, 1, 1, 1);
    done();
    st(10'h010, "program timeout");
    prog('{CMD_SUBSECTOR_ERA, 8'h00, 8'h30, 8'h00}, 1, 1, 1);
    done();
    st(10'h030, "erase timeout");
    clr();
    st(10'h000, "flags cleared");
    $display("test timeout done");
    cfg(1'b0, 1'b1, PROTO_EXTENDED);
    prog('{CMD_SUBSECTOR_ERA, 8'h01, 8'h23, 8'h45}, 1, 1, 1);
    st(10'h100, "subsector busy");
    chk(ner, 1, "subsector start");
    chk(er_sec, 1'b0, "subsector kind");
    chk(er_addr, 24'h012345, "subsector address");
    done();
    prog('{CMD_SECTOR_ERA, 8'h0a, 8'hbc, 8'hde}, 1, 1, 1);
    chk(er_sec, 1'b1, "sector kind");
    chk(er_addr, 24'h0abcde, "sector address");
    done();
    st(10'h000, "sector end");
    $display("test erase done");
    cfg(1'b1, 1'b1, PROTO_EXTENDED);
    prog('{CMD_PAGE_PROG, 8'h00, 8'h40, 8'h00, 8'h11}, 1, 1, 1);
    st(10'h212, "protected program");
    chk(nwr, 0, "protected writes");
    chk(check_addr, 24'h004000, "lookup address");
    clr();
    fr('{CMD_SECTOR_ERA, 8'h00, 8'h40, 8'h00});
    st(10'h222, "protected erase");
    chk(ner, 0, "protected erase start");
    clr();
    cfg(1'b0, 1'b1, PROTO_EXTENDED);
    $display("test protect done");
    prog('{CMD_PAGE_PROG, 8'h00, 8'h50, 8'h00, 8'h77}, 1, 1, 1);
    fr('{CMD_SUSPEND});
    st(10'h104, "suspended");
    cyc(700);
    st(10'h104, "still suspended");
    fr('{CMD_RESUME});
    st(10'h100, "resumed");
    done();
    st(10'h000, "resumed end");
    chk(mem[24'h005000], 8'h77, "resumed byte");
    $display("test suspend done");
    cfg(1'b0, 1'b1, PROTO_DUAL);
    prog('{CMD_DUAL_PROG, 8'h00, 8'h60, 8'h01, 8'h9c}, 2, 2, 2);
    done();
    chk(mem[24'h006001], 8'h9c, "dual program");
    prog('{CMD_QUAD_PROG, 8'h00, 8'h60, 8'h02, 8'h3c}, 2, 2, 2);
    st(10'h200, "quad in dual");
    chk(nwr, 0, "quad in dual writes");
    cfg(1'b0, 1'b1, PROTO_QUAD);
    prog('{CMD_EXT_QUAD_PROG, 8'h00, 8'h60, 8'h03, 8'hc3}, 4, 4, 4);
    done();
    chk(mem[24'h006003], 8'hc3, "quad program");
    cfg(1'b0, 1'b1, PROTO_EXTENDED);
    prog('{CMD_EXT_DUAL_PROG, 8'h00, 8'h60, 8'h04, 8'h5e}, 1, 2, 2);
    done();
    chk(mem[24'h006004], 8'h5e, "ext dual program");
    prog('{CMD_QUAD_PROG, 8'h00, 8'h60, 8'h05, 8'ha7}, 1, 1, 4);
    done();
    chk(mem[24'h006005], 8'ha7, "quad data lanes");
    $display("test lanes done");
    close_out();
  end
endmodule : serial_flash_program_erase_seq_tb_top
